/* core/sbs_pkg.sv */
// shared constants and types of the synchronous burst sram core
package sbs_pkg;

  // ==========================================================================
  // array geometry
  localparam int SBS_ADDR_W = 19;
  localparam int SBS_LANES = 4;
  localparam int SBS_LANE_W = 9;
  localparam int SBS_BURST_W = 2;

  // ==========================================================================
  // asynchronous pin synchroniser, also the sleep entry and wake delay
  localparam int SBS_SLEEP_CYC = 2;
  localparam int SBS_SYNC_LEN = SBS_SLEEP_CYC;
  localparam int SBS_ASYNC_W = 4;
  // bit positions in the synchronised vector
  localparam int SBS_BIT_OE_N = 3;
  localparam int SBS_BIT_SLEEP = 2;
  localparam int SBS_BIT_ORDER = 1;
  localparam int SBS_BIT_FT_N = 0;
  // reset: outputs disabled, awake, linear, pipeline
  localparam logic [SBS_ASYNC_W-1:0] SBS_ASYNC_RST = 4'h9;

  // ==========================================================================
  // burst type held between begin and continue cycles
  typedef enum logic [2:0]
  {
    SBS_BT_IDLE = 3'b001,
    SBS_BT_READ = 3'b010,
    SBS_BT_WRITE = 3'b100
  } sbs_burst_t;

endpackage

/* core/sbs_burst_ctr.sv */
// two-bit linear or interleaved burst address counter
`timescale 1ns/1ps
`default_nettype none
module sbs_burst_ctr
  import sbs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic advance,
  input wire logic interleave,
  input wire logic [SBS_BURST_W-1:0] start,
  output logic [SBS_BURST_W-1:0] next_low
);

  logic [SBS_BURST_W-1:0] start_r;
  logic [SBS_BURST_W-1:0] start_nxt;
  logic [SBS_BURST_W-1:0] cnt_r;
  logic [SBS_BURST_W-1:0] cnt_nxt;
  logic [SBS_BURST_W-1:0] cnt_inc;

  // ==========================================================================
  // count state
  always_comb
  begin
    cnt_inc = SBS_BURST_W'(cnt_r + 1'b1);
    start_nxt = start_r;
    cnt_nxt = cnt_r;
    if (load)
    begin
      start_nxt = start;
      cnt_nxt = '0;
    end
    else if (advance)
      cnt_nxt = cnt_inc; // two-bit count wraps on the fifth access
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      start_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      start_r <= start_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // low address of the access that the next advance uses
  assign next_low = interleave ? (start_r ^ cnt_inc)
                               : SBS_BURST_W'(start_r + cnt_inc);

endmodule
`default_nettype wire

/* core/sbs_sram_core.sv */
// command decode, burst control, data pipeline and array of the sync sram
`timescale 1ns/1ps
`default_nettype none
module sbs_sram_core
  import sbs_pkg::*;
#(
  parameter int ADDR_W = SBS_ADDR_W,
  parameter int LANES = SBS_LANES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_gate_n,
  input wire logic advance_load,
  input wire logic store_select_n,
  input wire logic chip_sel_a_n,
  input wire logic chip_sel_b,
  input wire logic chip_sel_c_n,
  input wire logic output_enable_n,
  input wire logic sleep_req,
  input wire logic burst_order_sel,
  input wire logic output_reg_bypass_n,
  input wire logic [LANES-1:0] byte_lane_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [LANES*SBS_LANE_W-1:0] data_in,
  output logic [LANES*SBS_LANE_W-1:0] data_out,
  output logic data_oe
);

  localparam int DW = LANES * SBS_LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // ==========================================================================
  // declarations
  logic [SBS_ASYNC_W-1:0] async_r [SBS_SYNC_LEN];
  logic [SBS_ASYNC_W-1:0] async_nxt [SBS_SYNC_LEN];
  logic [SBS_ASYNC_W-1:0] async_s;
  logic oe_off;
  logic sleeping;
  logic interleave;
  logic flow_mode;
  logic go;
  logic sel;
  logic any_lane;
  logic begin_rd;
  logic begin_wr;
  logic desel;
  logic cont;
  logic ctr_load;
  logic ctr_adv;
  logic [SBS_BURST_W-1:0] ctr_low;
  logic [ADDR_W-1:0] cmd_addr;
  sbs_burst_t burst_r;
  sbs_burst_t burst_nxt;
  logic [ADDR_W-1:0] base_r;
  logic [ADDR_W-1:0] base_nxt;
  logic s1_rd_r;
  logic s1_rd_nxt;
  logic s1_wr_r;
  logic s1_wr_nxt;
  logic [ADDR_W-1:0] s1_addr_r;
  logic [ADDR_W-1:0] s1_addr_nxt;
  logic [LANES-1:0] s1_lanes_r;
  logic [LANES-1:0] s1_lanes_nxt;
  logic s2_rd_r;
  logic s2_rd_nxt;
  logic s2_wr_r;
  logic s2_wr_nxt;
  logic [ADDR_W-1:0] s2_addr_r;
  logic [ADDR_W-1:0] s2_addr_nxt;
  logic [LANES-1:0] s2_lanes_r;
  logic [LANES-1:0] s2_lanes_nxt;
  logic [DW-1:0] rd1_r;
  logic [DW-1:0] rd1_nxt;
  logic [DW-1:0] rd2_r;
  logic [DW-1:0] rd2_nxt;
  logic pwr_up_r;
  logic pwr_up_nxt;
  logic wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [LANES-1:0] wr_lanes;
  logic [SBS_BURST_W-1:0] s1_low;
  logic [DW-1:0] mem [DEPTH];

  // ==========================================================================
  // asynchronous pins: two-stage synchroniser, the second stage is the delay
  always_comb
  begin
    async_nxt[0] = {output_enable_n, sleep_req, burst_order_sel, output_reg_bypass_n};
    for (int i = 1; i < SBS_SYNC_LEN; i++)
      async_nxt[i] = async_r[i-1];
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < SBS_SYNC_LEN; i++)
    begin
      if (rst)
        async_r[i] <= SBS_ASYNC_RST;
      else
        async_r[i] <= async_nxt[i];
    end
  end

  // synchronised levels
  assign async_s = async_r[SBS_SYNC_LEN-1];
  assign oe_off = async_s[SBS_BIT_OE_N];
  assign sleeping = async_s[SBS_BIT_SLEEP]; // follows request by two edges
  assign interleave = async_s[SBS_BIT_ORDER];
  assign flow_mode = ~async_s[SBS_BIT_FT_N];

  // ==========================================================================
  // command decode; a gated edge or sleep takes no command at all
  assign go = ~clk_gate_n & ~sleeping;
  assign sel = ~chip_sel_a_n & chip_sel_b & ~chip_sel_c_n;
  assign any_lane = ~&byte_lane_n;
  assign begin_rd = go & ~advance_load & sel & store_select_n;
  assign begin_wr = go & ~advance_load & sel & ~store_select_n;
  assign desel = go & ~advance_load & ~sel;
  assign cont = go & advance_load;
  assign ctr_load = begin_rd | (begin_wr & any_lane);
  assign ctr_adv = cont & (burst_r != SBS_BT_IDLE);
  assign cmd_addr = ctr_adv ? {base_r[ADDR_W-1:SBS_BURST_W], ctr_low} : addr;

  sbs_burst_ctr u_ctr
  (
    .clk(clk),
    .rst(rst),
    .load(ctr_load),
    .advance(ctr_adv),
    .interleave(interleave),
    .start(addr[SBS_BURST_W-1:0]),
    .next_low(ctr_low)
  );

  // ==========================================================================
  // burst type and base address
  always_comb
  begin
    burst_nxt = burst_r;
    base_nxt = base_r;
    if (begin_rd)
    begin
      burst_nxt = SBS_BT_READ;
      base_nxt = addr;
    end
    else if (begin_wr)
    begin
      // write abort at a load cycle counts as a deselect
      burst_nxt = any_lane ? SBS_BT_WRITE : SBS_BT_IDLE;
      base_nxt = any_lane ? addr : base_r;
    end
    else if (desel)
      burst_nxt = SBS_BT_IDLE; // store and lanes ignored
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      burst_r <= SBS_BT_IDLE;
      base_r <= '0;
    end
    else
    begin
      burst_r <= burst_nxt;
      base_r <= base_nxt;
    end
  end

  // ==========================================================================
  // command pipeline stages, frozen on a gated edge
  always_comb
  begin
    s1_rd_nxt = s1_rd_r;
    s1_wr_nxt = s1_wr_r;
    s1_addr_nxt = s1_addr_r;
    s1_lanes_nxt = s1_lanes_r;
    s2_rd_nxt = s2_rd_r;
    s2_wr_nxt = s2_wr_r;
    s2_addr_nxt = s2_addr_r;
    s2_lanes_nxt = s2_lanes_r;
    rd1_nxt = rd1_r;
    rd2_nxt = rd2_r;
    pwr_up_nxt = pwr_up_r & ~go;
    if (go)
    begin
      s1_rd_nxt = begin_rd | (ctr_adv & (burst_r == SBS_BT_READ));
      s1_wr_nxt = any_lane & (begin_wr | (ctr_adv & (burst_r == SBS_BT_WRITE)));
      s1_addr_nxt = cmd_addr;
      s1_lanes_nxt = ~byte_lane_n;
      s2_rd_nxt = s1_rd_r;
      s2_wr_nxt = s1_wr_r;
      s2_addr_nxt = s1_addr_r;
      s2_lanes_nxt = s1_lanes_r;
      // dummy reads still run the array, only the drivers stay off
      rd1_nxt = s1_rd_nxt ? mem[cmd_addr] : rd1_r;
      rd2_nxt = rd1_r; // output register of pipeline mode
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_rd_r <= 1'b0;
      s1_wr_r <= 1'b0;
      s1_addr_r <= '0;
      s1_lanes_r <= '0;
      s2_rd_r <= 1'b0;
      s2_wr_r <= 1'b0;
      s2_addr_r <= '0;
      s2_lanes_r <= '0;
      rd1_r <= '0;
      rd2_r <= '0;
      pwr_up_r <= 1'b1;
    end
    else
    begin
      s1_rd_r <= s1_rd_nxt;
      s1_wr_r <= s1_wr_nxt;
      s1_addr_r <= s1_addr_nxt;
      s1_lanes_r <= s1_lanes_nxt;
      s2_rd_r <= s2_rd_nxt;
      s2_wr_r <= s2_wr_nxt;
      s2_addr_r <= s2_addr_nxt;
      s2_lanes_r <= s2_lanes_nxt;
      rd1_r <= rd1_nxt;
      rd2_r <= rd2_nxt;
      pwr_up_r <= pwr_up_nxt;
    end
  end

  // ==========================================================================
  // late write into the array, one or two edges after the command
  assign wr_go = go & (flow_mode ? s1_wr_r : s2_wr_r);
  assign wr_addr = flow_mode ? s1_addr_r : s2_addr_r;
  assign wr_lanes = flow_mode ? s1_lanes_r : s2_lanes_r;

  always_ff @(posedge clk)
  begin
    if (wr_go)
    begin
      for (int l = 0; l < LANES; l++)
      begin
        if (wr_lanes[l])
          mem[wr_addr][l*SBS_LANE_W +: SBS_LANE_W] <= data_in[l*SBS_LANE_W +: SBS_LANE_W];
      end
    end
  end

  // ==========================================================================
  // data bus drive; write stages never drive
  assign data_out = flow_mode ? rd1_r : rd2_r;
  assign data_oe = ~pwr_up_r & ~sleeping & ~oe_off
                   & (flow_mode ? s1_rd_r : s2_rd_r);

  // ==========================================================================
  // checks
  assign s1_low = s1_addr_r[SBS_BURST_W-1:0];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_read_begin: assert property (begin_rd |=> s1_rd_r && !s1_wr_r && s1_addr_r == $past(addr))
    else $error("read begin not registered");
  chk_dummy_off: assert property (oe_off |-> !data_oe)
    else $error("bus driven with output enable off");
  chk_write_begin: assert property (begin_wr && any_lane
    |=> s1_wr_r ##1 (!$past(go) || s2_wr_r))
    else $error("write begin not registered");
  chk_abort_none: assert property (go && !store_select_n && !any_lane |=> !s1_wr_r)
    else $error("write with no lane enabled");
  chk_deselect: assert property (desel |=> !s1_rd_r && !s1_wr_r && burst_r == SBS_BT_IDLE)
    else $error("deselect left a burst active");
  chk_cont_read: assert property (cont && burst_r == SBS_BT_READ |=> s1_rd_r)
    else $error("read continue dropped");
  chk_stall_hold: assert property (clk_gate_n |=> $stable(s1_addr_r) && $stable(s2_rd_r) && $stable(rd2_r))
    else $error("state moved on a gated edge");
  chk_write_nodrive: assert property ((flow_mode ? s1_wr_r : s2_wr_r) |-> !data_oe)
    else $error("bus driven in a write cycle");
  chk_linear_step: assert property (ctr_adv && !interleave |=> s1_low == SBS_BURST_W'($past(s1_low) + 1'b1))
    else $error("linear burst step wrong");
  chk_sleep_off: assert property ($rose(sleep_req) ##1 sleep_req |=> sleeping && !data_oe)
    else $error("sleep not entered after two cycles");
  chk_powerup_off: assert property (pwr_up_r |-> !data_oe)
    else $error("bus driven before first command");

endmodule
`default_nettype wire

/* bench/sbs_ctl_model.sv */
// controller-side model that drives the command and write data bus
`timescale 1ns/1ps
`default_nettype none
module sbs_ctl_model
  import sbs_pkg::*;
(
  input wire logic clk,
  input wire logic [SBS_LANES*SBS_LANE_W-1:0] data_out,
  input wire logic data_oe,
  output logic clk_gate_n,
  output logic advance_load,
  output logic store_select_n,
  output logic chip_sel_a_n,
  output logic chip_sel_b,
  output logic chip_sel_c_n,
  output logic [SBS_LANES-1:0] byte_lane_n,
  output logic [SBS_ADDR_W-1:0] addr,
  output logic [SBS_LANES*SBS_LANE_W-1:0] data_in
);
  // ==========================================================================
  // device output seen just before each drive
  logic [SBS_LANES*SBS_LANE_W:0] obs;

  // deselected and idle from time zero on
  initial
  begin
    obs = '0;
    clk_gate_n = 1'b0;
    advance_load = 1'b0; // a plain deselect precedes any continue
    store_select_n = 1'b1;
    chip_sel_a_n = 1'b1;
    chip_sel_b = 1'b0;
    chip_sel_c_n = 1'b1;
    byte_lane_n = '1;
    addr = '0;
    data_in = '0;
  end

  // one cycle driven after the falling edge, held over the rising edge
  task automatic cyc(input logic g, input logic a, input logic w, input logic s,
    input logic [SBS_LANES-1:0] l, input logic [SBS_ADDR_W-1:0] ad, input logic dv,
    input logic [SBS_LANES*SBS_LANE_W-1:0] d);
    @(negedge clk);
    obs = {data_oe, data_out};
    clk_gate_n <= g;
    advance_load <= a;
    store_select_n <= w;
    chip_sel_a_n <= !s;
    chip_sel_b <= s;
    chip_sel_c_n <= !s;
    byte_lane_n <= l;
    addr <= ad;
    // write data only in its late slot, else a changing pattern
    data_in <= dv ? d : ~data_in;
  endtask
endmodule
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench of the synchronous burst sram core
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sbs_pkg::*;
();
  // ==========================================================================
  // signals
  localparam int DW = SBS_LANES*SBS_LANE_W;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic output_enable_n = 1'b0;
  logic sleep_req = 1'b0;
  logic burst_order_sel = 1'b0;
  logic output_reg_bypass_n = 1'b1;
  logic clk_gate_n, advance_load, store_select_n, chip_sel_a_n, chip_sel_b, chip_sel_c_n;
  logic [SBS_LANES-1:0] byte_lane_n;
  logic [SBS_ADDR_W-1:0] addr;
  logic [DW-1:0] data_in, data_out;
  logic data_oe;
  logic [DW-1:0] mem [int];
  int error_cnt = 0;
  int n_tests = 0;

  // clock of 25 ns
  always #12.5 clk = ~clk;

  // ==========================================================================
  // design and controller model
  sbs_sram_core dut_u
  (
    .clk(clk), .rst(rst), .clk_gate_n(clk_gate_n), .advance_load(advance_load),
    .store_select_n(store_select_n), .chip_sel_a_n(chip_sel_a_n), .chip_sel_b(chip_sel_b),
    .chip_sel_c_n(chip_sel_c_n), .output_enable_n(output_enable_n), .sleep_req(sleep_req),
    .burst_order_sel(burst_order_sel), .output_reg_bypass_n(output_reg_bypass_n),
    .byte_lane_n(byte_lane_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe)
  );
  sbs_ctl_model ctl_u
  (
    .clk(clk), .data_out(data_out), .data_oe(data_oe), .clk_gate_n(clk_gate_n),
    .advance_load(advance_load), .store_select_n(store_select_n),
    .chip_sel_a_n(chip_sel_a_n), .chip_sel_b(chip_sel_b), .chip_sel_c_n(chip_sel_c_n),
    .byte_lane_n(byte_lane_n), .addr(addr), .data_in(data_in)
  );

  // ==========================================================================
  // helpers
  function automatic logic [SBS_ADDR_W-1:0] seq(input logic [SBS_ADDR_W-1:0] st, input int j,
    input logic ilv);
    logic [1:0] lo;
    lo = ilv ? (st[1:0] ^ 2'(j)) : (st[1:0] + 2'(j));
    return {st[SBS_ADDR_W-1:2], lo};
  endfunction

  function automatic logic [DW-1:0] pat(input logic [SBS_ADDR_W-1:0] a, input logic inv);
    return inv ? {~a[17:0], a[17:0]} : {a[17:0], ~a[17:0]};
  endfunction

  task automatic chk(input string nm, input logic [DW:0] exp, input logic [DW:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  // set straps, enable and sleep, then let them settle over deselects
  task automatic mode(input logic bo, input logic ft, input logic oe, input logic sl);
    @(negedge clk);
    burst_order_sel <= bo;
    output_reg_bypass_n <= ft;
    output_enable_n <= oe;
    sleep_req <= sl;
    repeat (3) ctl_u.cyc(1'b0, 1'b0, 1'b1, 1'b0, '1, '0, 1'b0, '0);
  endtask

  // four-beat write burst, data lat cycles behind each command
  task automatic wr_burst(input logic [SBS_ADDR_W-1:0] st, input logic ilv, input int lat,
    input logic [SBS_LANES-1:0] ln, input logic inv);
    logic [SBS_ADDR_W-1:0] a;
    logic [DW-1:0] d;
    for (int i = 0; i < 6; i++)
    begin
      a = seq(st, i - lat, ilv);
      d = pat(a, inv);
      if (i >= lat && i - lat < 4)
        for (int l = 0; l < SBS_LANES; l++)
          if (!ln[l])
            mem[a][l*SBS_LANE_W +: SBS_LANE_W] = d[l*SBS_LANE_W +: SBS_LANE_W];
      ctl_u.cyc(1'b0, i > 0 && i < 4, 1'b0, i == 0, ln, st, i >= lat && i - lat < 4, d);
    end
  endtask

  // five-beat read burst, the fifth wraps to the start; optional gated edge
  task automatic rd_burst(input logic [SBS_ADDR_W-1:0] st, input logic ilv, input int lat,
    input logic dr, input logic stl);
    logic [DW:0] s [0:7];
    logic [SBS_ADDR_W-1:0] a;
    for (int i = 0; i < 8; i++)
    begin
      if (stl && i == 2)
      begin
        ctl_u.cyc(1'b1, 1'b1, 1'b1, 1'b0, '1, '0, 1'b0, '0);
        s[i] = ctl_u.obs;
      end
      ctl_u.cyc(1'b0, i > 0 && i < 5, 1'b1, i == 0, '1, st, 1'b0, '0);
      if (stl && i == 2)
        chk("held output", s[i], ctl_u.obs);
      else
        s[i] = ctl_u.obs;
    end
    for (int j = 0; j < 5; j++)
    begin
      a = seq(st, j, ilv);
      chk("read word", dr ? {1'b1, mem[a]} : {1'b0, s[j + lat][DW-1:0]}, s[j + lat]);
    end
    chk("drive after deselect", 1'b0, s[lat + 5][DW]);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_pipe();
    mode(1'b0, 1'b1, 1'b0, 1'b0);
    wr_burst(19'h00041, 1'b0, 2, 4'h0, 1'b0);
    rd_burst(19'h00041, 1'b0, 2, 1'b1, 1'b1);
    $display("test pipeline burst done");
  endtask

  task automatic t_lanes();
    mode(1'b1, 1'b1, 1'b0, 1'b0);
    rd_burst(19'h00041, 1'b1, 2, 1'b1, 1'b0);
    wr_burst(19'h00042, 1'b1, 2, 4'b0101, 1'b1);
    wr_burst(19'h00040, 1'b1, 2, 4'hF, 1'b0);
    rd_burst(19'h00040, 1'b1, 2, 1'b1, 1'b0);
    mode(1'b0, 1'b1, 1'b1, 1'b0);
    rd_burst(19'h00040, 1'b0, 2, 1'b0, 1'b0);
    $display("test lanes and order done");
  endtask

  task automatic t_flow();
    mode(1'b0, 1'b0, 1'b0, 1'b0);
    wr_burst(19'h00102, 1'b0, 1, 4'h0, 1'b0);
    rd_burst(19'h00102, 1'b0, 1, 1'b1, 1'b0);
    $display("test flow-through done");
  endtask

  task automatic t_sleep();
    mode(1'b0, 1'b1, 1'b0, 1'b1); // raised with nothing pending
    rd_burst(19'h00102, 1'b0, 2, 1'b0, 1'b0);
    mode(1'b0, 1'b1, 1'b0, 1'b0); // only deselects while waking
    rd_burst(19'h00102, 1'b0, 2, 1'b1, 1'b0);
    $display("test sleep done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence after three reset cycles
  initial
  begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst <= 1'b0;
    chk("drive at power-up", 1'b0, data_oe);
    t_pipe();
    t_lanes();
    t_flow();
    t_sleep();
    stop_test();
  end

  // watchdog well beyond the hundred or so cycles of the run
  initial
  begin
    #100000;
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
